// ---- cgc_regs.sv ----
// Banked PWM gate-current configuration registers and channel selection.
// Assumes a serial frame decoder on clk_sys_i presents one access at a time.
//
// Behaviour
// - Freewheel register at bank 1, offset 0x0b
// - Three 5-bit freewheel codes, on and off
// - Bit 15 reserved, reads zero
// - Freewheel register resets to 0x18c6
// - Bank 0 0x0c discharge codes, reset 0x1ce7
// - Bit 15 at 0x0c selects sense load
// - Bank 1 0x0c predischarge codes, reset 0x318c
// - Bank 0 0x0d timing codes, reset 0x4900
// - 2-bit max drive codes per channel
// - Max drive code also used post-charge
// - Bank 0 0x0b active charge codes
`timescale 1ns/1ps
// Offsets, field positions and reset words of the map
`include "cgc_map.svh"

module cgc_regs
   import cgc_pkg::*;
#(
   parameter int NUM_CH = 3                          // PWM channels
) (
   input  wire logic                clk_sys_i,       // System clock, 40 MHz
   input  wire logic                rst_n_i,         // Async reset, active low
   input  wire cgc_pkg::cgc_acc_s   acc_i,           // Register access request
   input  wire cgc_pkg::cgc_phase_e phase_i [3],     // Drive phase per channel
   output logic [15:0]              rdata_o,         // Read data
   output logic                     rvalid_o,        // Read data valid pulse
   output cgc_pkg::cgc_cfg_s        cfg_o,           // All configuration fields
   output cgc_pkg::cgc_drive_s      drive_o [3]      // Current choice per channel
);
   import cgc_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // Field layout is fixed at three channels of 5-bit codes
   if (NUM_CH != 3) begin : g_bad_ch
      $error("cgc_regs supports exactly three PWM channels");
   end

   // Three codes per word must fill bits 14:0 exactly
   if (`CGC_CODES_W != 3 * `CGC_CODE_W) begin : g_bad_codes
      $error("cgc_regs code fields do not fill the word");
   end

   // Three max drive codes must fill bits 5:0 exactly
   if (`CGC_MAXDRV_ALL_W != 3 * `CGC_MAXDRV_W) begin : g_bad_maxdrv
      $error("cgc_regs max drive fields do not fill bits 5:0");
   end

   // Timing fields must end just below the reserved bit
   if (`CGC_POS_BLANK3 + 3 * `CGC_TIME_W != `CGC_BIT_TOP) begin : g_bad_timing
      $error("cgc_regs timing fields overlap the reserved bit");
   end

   // ----------------------------------------
   // Reset words
   // ----------------------------------------
   // Named constants, so reset can pick single fields out of them
   localparam logic [15:0] RST_CHARGE_ACT   = `CGC_RST_CHARGE_ACT;
   localparam logic [15:0] RST_FREEWHEEL    = `CGC_RST_FREEWHEEL;
   localparam logic [15:0] RST_DISCHARGE    = `CGC_RST_DISCHARGE;
   localparam logic [15:0] RST_PREDISCHARGE = `CGC_RST_PREDISCHARGE;
   localparam logic [15:0] RST_TIMING       = `CGC_RST_TIMING;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Low 15 bits of a 16-bit word as three codes
   function automatic cgc_codes_t codes_of(input logic [15:0] w);
      codes_of = cgc_codes_t'(w[`CGC_CODES_W-1:0]);
   endfunction

   // Three codes back to a word, top bit given by the caller
   function automatic logic [15:0] word_of(input cgc_codes_t c, input logic top);
      word_of = {top, c};
   endfunction

   // Bank and offset must both match for a hit
   function automatic logic hit(input cgc_acc_s a, input logic bank,
                                input logic [4:0] ofs);
      hit = (a.bank == bank) && (a.addr == ofs);
   endfunction

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   cgc_codes_t  charge_act_q,   charge_act_d;
   cgc_codes_t  freewheel_q,    freewheel_d;
   cgc_codes_t  discharge_q,    discharge_d;
   cgc_codes_t  predischarge_q, predischarge_d;
   logic        sense_load_q,   sense_load_d;
   logic [2:0]  blank4_q,       blank4_d;
   logic [2:0]  ccp4_q,         ccp4_d;
   logic [2:0]  blank3_q,       blank3_d;
   cgc_maxdrv_t maxdrv_q,       maxdrv_d;

   logic wr_charge_act;
   logic wr_freewheel;
   logic wr_discharge;
   logic wr_predischarge;
   logic wr_timing;

   // Write decode, one target at most per access
   always_comb begin
      wr_charge_act   = acc_i.wr && hit(acc_i, `CGC_BANK_ACTIVE,
                                        `CGC_OFS_CHARGE);
      wr_freewheel    = acc_i.wr && hit(acc_i, `CGC_BANK_FREEWHEEL,
                                        `CGC_OFS_CHARGE);
      wr_discharge    = acc_i.wr && hit(acc_i, `CGC_BANK_ACTIVE,
                                        `CGC_OFS_DISCHARGE);
      wr_predischarge = acc_i.wr && hit(acc_i, `CGC_BANK_FREEWHEEL,
                                        `CGC_OFS_DISCHARGE);
      wr_timing       = acc_i.wr && hit(acc_i, `CGC_BANK_ACTIVE,
                                        `CGC_OFS_TIMING);
   end

   // Next register values; bit 15 is dropped except at 0x0c, where it loads sense load
   always_comb begin
      charge_act_d   = charge_act_q;
      freewheel_d    = freewheel_q;
      discharge_d    = discharge_q;
      predischarge_d = predischarge_q;
      sense_load_d   = sense_load_q;
      blank4_d       = blank4_q;
      ccp4_d         = ccp4_q;
      blank3_d       = blank3_q;
      maxdrv_d       = maxdrv_q;
      if (wr_charge_act) begin
         charge_act_d = codes_of(acc_i.wdata);
      end
      if (wr_freewheel) begin
         freewheel_d = codes_of(acc_i.wdata);
      end
      if (wr_discharge) begin
         discharge_d  = codes_of(acc_i.wdata);
         sense_load_d = acc_i.wdata[`CGC_BIT_TOP];
      end
      if (wr_predischarge) begin
         predischarge_d = codes_of(acc_i.wdata);
         sense_load_d   = acc_i.wdata[`CGC_BIT_TOP];
      end
      if (wr_timing) begin
         blank4_d = acc_i.wdata[`CGC_POS_BLANK4 +: `CGC_TIME_W];
         ccp4_d   = acc_i.wdata[`CGC_POS_CCP4 +: `CGC_TIME_W];
         blank3_d = acc_i.wdata[`CGC_POS_BLANK3 +: `CGC_TIME_W];
         maxdrv_d = cgc_maxdrv_t'(acc_i.wdata[`CGC_MAXDRV_ALL_W-1:0]);
      end
   end

   // Register update; reset loads the printed defaults
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         charge_act_q   <= codes_of(RST_CHARGE_ACT);
         freewheel_q    <= codes_of(RST_FREEWHEEL);
         discharge_q    <= codes_of(RST_DISCHARGE);
         predischarge_q <= codes_of(RST_PREDISCHARGE);
         sense_load_q   <= RST_DISCHARGE[`CGC_BIT_TOP];
         blank4_q       <= RST_TIMING[`CGC_POS_BLANK4 +: `CGC_TIME_W];
         ccp4_q         <= RST_TIMING[`CGC_POS_CCP4 +: `CGC_TIME_W];
         blank3_q       <= RST_TIMING[`CGC_POS_BLANK3 +: `CGC_TIME_W];
         maxdrv_q       <= cgc_maxdrv_t'(RST_TIMING[`CGC_MAXDRV_ALL_W-1:0]);
      end else begin
         charge_act_q   <= charge_act_d;
         freewheel_q    <= freewheel_d;
         discharge_q    <= discharge_d;
         predischarge_q <= predischarge_d;
         sense_load_q   <= sense_load_d;
         blank4_q       <= blank4_d;
         ccp4_q         <= ccp4_d;
         blank3_q       <= blank3_d;
         maxdrv_q       <= maxdrv_d;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [15:0] rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d;
   logic [15:0] timing_word;

   // Timing word with reserved top bit held at zero
   always_comb begin
      timing_word = {1'b0, blank4_q, ccp4_q, blank3_q, maxdrv_q};
   end

   // Read mux; unmapped bank/offset pairs read as zero
   always_comb begin
      rvalid_d = acc_i.rd;
      rdata_d  = 16'h0000;
      if (acc_i.rd) begin
         case ({acc_i.bank, acc_i.addr})
            {`CGC_BANK_ACTIVE, `CGC_OFS_CHARGE}: begin
               rdata_d = word_of(charge_act_q, 1'b0);
            end
            {`CGC_BANK_FREEWHEEL, `CGC_OFS_CHARGE}: begin
               rdata_d = word_of(freewheel_q, 1'b0);
            end
            {`CGC_BANK_ACTIVE, `CGC_OFS_DISCHARGE}: begin
               rdata_d = word_of(discharge_q, sense_load_q);
            end
            {`CGC_BANK_FREEWHEEL, `CGC_OFS_DISCHARGE}: begin
               rdata_d = word_of(predischarge_q, sense_load_q);
            end
            {`CGC_BANK_ACTIVE, `CGC_OFS_TIMING}: begin
               rdata_d = timing_word;
            end
            default: begin
               rdata_d = 16'h0000;
            end
         endcase
      end
   end

   // Read data registered so the port comes from a flop
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ----------------------------------------
   // Configuration and per-channel current choice
   // ----------------------------------------
   cgc_cfg_s   cfg_q,   cfg_d;
   cgc_drive_s drive_q [3];
   cgc_drive_s drive_d [3];

   // Gather the fields for the gate drivers
   always_comb begin
      cfg_d.charge_act                     = charge_act_q;
      cfg_d.freewheeling                   = freewheel_q;
      cfg_d.active_discharge               = discharge_q;
      cfg_d.initial_predischarge           = predischarge_q;
      cfg_d.sense_amp_output               = sense_load_q;
      cfg_d.active_blank_time_4            = blank4_q;
      cfg_d.active_cross_conduction_time_4 = ccp4_q;
      cfg_d.active_blank_time_3            = blank3_q;
      cfg_d.max_drive_current              = maxdrv_q;
   end

   // Max drive code rules the pre and post phases; costs one cycle
   // of lag behind phase_i, traded for flop-driven outputs
   always_comb begin
      for (int ch = 0; ch < 3; ch++) begin
         drive_d[ch].max_code = maxdrv_q[ch];
         drive_d[ch].fw_code  = freewheel_q[ch];
         drive_d[ch].use_max  = 1'b0;
         drive_d[ch].code     = 5'h00;
         case (phase_i[ch])
            CGC_PH_PRE_CHARGE: begin
               drive_d[ch].use_max = 1'b1;
            end
            CGC_PH_CHARGE: begin
               drive_d[ch].code = charge_act_q[ch];
            end
            CGC_PH_POST_CHARGE: begin
               drive_d[ch].use_max = 1'b1;
            end
            CGC_PH_PRE_DISCHARGE: begin
               drive_d[ch].use_max = 1'b1;
            end
            CGC_PH_DISCHARGE: begin
               drive_d[ch].code = discharge_q[ch];
            end
            default: begin
               drive_d[ch].code = 5'h00;
            end
         endcase
      end
   end

   // Output registers
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_q <= '0;
         for (int ch = 0; ch < 3; ch++) begin
            drive_q[ch] <= '0;
         end
      end else begin
         cfg_q <= cfg_d;
         for (int ch = 0; ch < 3; ch++) begin
            drive_q[ch] <= drive_d[ch];
         end
      end
   end

   // ----------------------------------------
   // Port drive
   // ----------------------------------------
   assign rdata_o  = rdata_q;
   assign rvalid_o = rvalid_q;
   assign cfg_o    = cfg_q;
   assign drive_o  = drive_q;

endmodule

// ---- cgc_map.svh ----
// Offsets, field positions and reset values of the PWM gate-current bank.
// Assumes the includer works in 16-bit register words and 5-bit offsets.
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH

// ----------------------------------------
// Offsets; 0x0b and 0x0c in both banks, 0x0d in bank 0 only
// ----------------------------------------
`define CGC_OFS_CHARGE       5'h0b
`define CGC_OFS_DISCHARGE    5'h0c
`define CGC_OFS_TIMING       5'h0d
`define CGC_BANK_ACTIVE      1'b0
`define CGC_BANK_FREEWHEEL   1'b1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CGC_RST_CHARGE_ACT   16'h18c6
`define CGC_RST_FREEWHEEL    16'h18c6
`define CGC_RST_DISCHARGE    16'h1ce7
`define CGC_RST_PREDISCHARGE 16'h318c
`define CGC_RST_TIMING       16'h4900

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CGC_CODE_W           5
`define CGC_MAXDRV_W         2
`define CGC_TIME_W           3
`define CGC_BIT_TOP          15
`define CGC_POS_BLANK4       12
`define CGC_POS_CCP4         9
`define CGC_POS_BLANK3       6
`define CGC_CODES_W          15
`define CGC_MAXDRV_ALL_W     6

`endif

// ---- cgc_pkg.sv ----
// Types of the PWM gate-current configuration bank.
// Assumes cgc_map.svh is on the include path.
package cgc_pkg;
   `include "cgc_map.svh"

   // ----------------------------------------
   // Register access request, one per cycle
   // ----------------------------------------
   typedef struct packed {
      logic        wr;     // Write strobe
      logic        rd;     // Read strobe
      logic        bank;   // Bank select
      logic [4:0]  addr;   // Register offset
      logic [15:0] wdata;  // Write data
   } cgc_acc_s;

   // Gate-drive phase of one PWM channel, Gray along the usual path
   typedef enum logic [2:0] {
      CGC_PH_IDLE          = 3'h0,
      CGC_PH_PRE_CHARGE    = 3'h1,
      CGC_PH_CHARGE        = 3'h3,
      CGC_PH_POST_CHARGE   = 3'h2,
      CGC_PH_PRE_DISCHARGE = 3'h6,
      CGC_PH_DISCHARGE     = 3'h7
   } cgc_phase_e;

   typedef logic [2:0][4:0] cgc_codes_t;
   typedef logic [2:0][1:0] cgc_maxdrv_t;

   // All configuration fields as seen by the gate drivers
   typedef struct packed {
      cgc_codes_t  charge_act;
      cgc_codes_t  freewheeling;
      cgc_codes_t  active_discharge;
      cgc_codes_t  initial_predischarge;
      logic        sense_amp_output;
      logic [2:0]  active_blank_time_4;
      logic [2:0]  active_cross_conduction_time_4;
      logic [2:0]  active_blank_time_3;
      cgc_maxdrv_t max_drive_current;
   } cgc_cfg_s;

   // Current selection handed to one channel's driver
   typedef struct packed {
      logic       use_max;   // Max drive code governs
      logic [1:0] max_code;  // Max drive current code
      logic [4:0] code;      // Active transistor code
      logic [4:0] fw_code;   // Freewheeling transistor code
   } cgc_drive_s;
endpackage

// ---- cgc_regs_assertions.sv ----
// Port-level assertions for the PWM gate-current register bank.
// Assumes one clock domain and binding onto every cgc_regs instance.
`timescale 1ns/1ps

module cgc_regs_assertions
   import cgc_pkg::*;
(
   input wire logic                clk_sys_i,   // System clock
   input wire logic                rst_n_i,     // Async reset, active low
   input wire cgc_pkg::cgc_acc_s   acc_i,       // Access request
   input wire cgc_pkg::cgc_phase_e phase_i [3], // Drive phase per channel
   input wire logic [15:0]         rdata_o,     // Read data
   input wire logic                rvalid_o,    // Read valid pulse
   input wire cgc_pkg::cgc_cfg_s   cfg_o,       // Configuration fields
   input wire cgc_pkg::cgc_drive_s drive_o [3]  // Drive selection
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // ----------------------------------------
   // Write decodes; a write in the next cycle reaches cfg_o only after the check
   // ----------------------------------------
   logic fw_wr;
   logic dis_wr;
   logic tim_wr;
   assign fw_wr  = acc_i.wr && acc_i.bank && acc_i.addr == 5'h0b;
   assign dis_wr = acc_i.wr && acc_i.addr == 5'h0c;
   assign tim_wr = acc_i.wr && !acc_i.bank && acc_i.addr == 5'h0d;

   read_pulse_a: assert property (acc_i.rd |=> rvalid_o)
      else $error("read not answered next cycle");
   idle_read_a: assert property (!acc_i.rd |=> !rvalid_o && rdata_o == 16'h0000)
      else $error("read data without a read");
   rsvd_bit_a: assert property (acc_i.rd && acc_i.addr != 5'h0c |=> !rdata_o[15])
      else $error("reserved bit read as one");
   fw_write_a: assert property (fw_wr ##1 !fw_wr |=>
      cfg_o.freewheeling == $past(acc_i.wdata[14:0], 2))
      else $error("freewheel codes not written");
   dis_write_a: assert property (dis_wr && !acc_i.bank ##1 !dis_wr |=>
      {cfg_o.sense_amp_output, cfg_o.active_discharge} == $past(acc_i.wdata, 2))
      else $error("discharge codes or sense load not written");
   tim_write_a: assert property (tim_wr ##1 !tim_wr |=>
      {cfg_o.active_blank_time_4, cfg_o.active_cross_conduction_time_4,
       cfg_o.active_blank_time_3, cfg_o.max_drive_current} == $past(acc_i.wdata[14:0], 2))
      else $error("timing codes not written");
   post_charge_a: assert property (phase_i[0] == CGC_PH_POST_CHARGE |=>
      drive_o[0].use_max && drive_o[0].code == 5'h00)
      else $error("post-charge without max drive");
   pre_charge_a: assert property (phase_i[1] == CGC_PH_PRE_CHARGE |=> drive_o[1].use_max)
      else $error("pre-charge without max drive");
   charge_plain_a: assert property (phase_i[2] == CGC_PH_CHARGE |=> !drive_o[2].use_max)
      else $error("charge phase used max drive");
endmodule

bind cgc_regs cgc_regs_assertions i_chk (
   .clk_sys_i(clk_sys_i),
   .rst_n_i  (rst_n_i),
   .acc_i    (acc_i),
   .phase_i  (phase_i),
   .rdata_o  (rdata_o),
   .rvalid_o (rvalid_o),
   .cfg_o    (cfg_o),
   .drive_o  (drive_o)
);

// ---- tb_pwm_gate_current_config_regs.sv ----
// Self-checking bench for the PWM gate-current register bank.
// Assumes cgc_pkg is compiled first; a shadow model predicts every read.
`timescale 1ns/1ps

module tb_pwm_gate_current_config_regs;
   import cgc_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   cgc_acc_s    acc_i     = '0;
   cgc_phase_e  phase_i [3] = '{CGC_PH_IDLE, CGC_PH_IDLE, CGC_PH_IDLE};
   logic [15:0] rdata_o;
   logic        rvalid_o;
   cgc_cfg_s    cfg_o;
   cgc_drive_s  drive_o [3];
   int          n_errors    = 0;
   int          comparisons = 0;
   int          seed        = 32'h44ec52bc;
   logic [15:0] m [2][3];   // Shadow registers, bit 15 held apart
   logic        sense = 1'b0;
   // Last two entries are the undefined phase codes, which select nothing
   cgc_phase_e  ph_tab [8] = '{CGC_PH_IDLE, CGC_PH_PRE_CHARGE, CGC_PH_CHARGE,
      CGC_PH_POST_CHARGE, CGC_PH_PRE_DISCHARGE, CGC_PH_DISCHARGE,
      cgc_phase_e'(3'h4), cgc_phase_e'(3'h5)};

   // 40 MHz clock
   always #12.5 clk_sys_i = ~clk_sys_i;

   cgc_regs #(.NUM_CH(3)) i_dut (
      .clk_sys_i(clk_sys_i),
      .rst_n_i  (rst_n_i),
      .acc_i    (acc_i),
      .phase_i  (phase_i),
      .rdata_o  (rdata_o),
      .rvalid_o (rvalid_o),
      .cfg_o    (cfg_o),
      .drive_o  (drive_o)
   );

   // ----------------------------------------
   // Checking and prediction
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic mapped(input logic b, input logic [4:0] a);
      return a >= 5'h0b && a <= 5'h0d && !(b && a == 5'h0d);
   endfunction

   // Sense load flop is shared, so both banks show it at 0x0c
   function automatic logic [15:0] exp_rd(input logic b, input logic [4:0] a);
      if (!mapped(b, a))
         return 16'h0000;
      return m[b][a - 5'h0b] | {(a == 5'h0c) & sense, 15'h0000};
   endfunction

   function automatic cgc_drive_s exp_drv(input cgc_phase_e p, input int n);
      cgc_drive_s e;
      e.use_max  = p inside {CGC_PH_PRE_CHARGE, CGC_PH_POST_CHARGE, CGC_PH_PRE_DISCHARGE};
      e.max_code = m[0][2][2*n +: 2];
      e.code     = (p == CGC_PH_CHARGE) ? m[0][0][5*n +: 5] :
                   (p == CGC_PH_DISCHARGE) ? m[0][1][5*n +: 5] : 5'h00;
      e.fw_code  = m[1][0][5*n +: 5];
      return e;
   endfunction

   // One access; a read expects the value from before its own write
   task automatic op(input logic w, input logic r, input logic b,
                     input logic [4:0] a, input logic [15:0] d);
      logic [15:0] e;
      e = exp_rd(b, a);
      @(posedge clk_sys_i);
      acc_i <= '{wr: w, rd: r, bank: b, addr: a, wdata: d};
      @(posedge clk_sys_i);
      acc_i <= '0;
      #1;
      chk({15'h0000, rvalid_o}, {15'h0000, r});
      if (r)
         chk(rdata_o, e);
      if (w && mapped(b, a)) begin
         m[b][a - 5'h0b] = d & 16'h7fff;
         if (a == 5'h0c)
            sense = d[15];
      end
   endtask

   // Phases per channel by table index, drive checked one cycle on
   task automatic phases(input int c0, input int c1, input int c2);
      int c [3];
      c = '{c0, c1, c2};
      @(posedge clk_sys_i);
      for (int n = 0; n < 3; n++)
         phase_i[n] <= ph_tab[c[n]];
      @(posedge clk_sys_i);
      #1;
      for (int n = 0; n < 3; n++)
         chk({3'h0, drive_o[n]}, {3'h0, exp_drv(ph_tab[c[n]], n)});
      // Configuration port, settled at least one edge after the last write
      chk({1'b0, cfg_o.charge_act}, m[0][0]);
      chk({1'b0, cfg_o.freewheeling}, m[1][0]);
      chk({cfg_o.sense_amp_output, cfg_o.active_discharge}, exp_rd(1'b0, 5'h0c));
      chk({cfg_o.sense_amp_output, cfg_o.initial_predischarge}, exp_rd(1'b1, 5'h0c));
      chk({1'b0, cfg_o.active_blank_time_4, cfg_o.active_cross_conduction_time_4,
           cfg_o.active_blank_time_3, cfg_o.max_drive_current}, m[0][2]);
   endtask

   // Shadow back to the reset values, then read both banks at offsets 0x0b to 0x0d
   task automatic read_defaults;
      m[0] = '{16'h18c6, 16'h1ce7, 16'h4900};
      m[1] = '{16'h18c6, 16'h318c, 16'h0000};
      sense = 1'b0;
      op(1'b0, 1'b1, 1'b0, 5'h0b, 16'h0000);
      op(1'b0, 1'b1, 1'b1, 5'h0b, 16'h0000);
      op(1'b0, 1'b1, 1'b0, 5'h0c, 16'h0000);
      op(1'b0, 1'b1, 1'b1, 5'h0c, 16'h0000);
      op(1'b0, 1'b1, 1'b0, 5'h0d, 16'h0000);
      op(1'b0, 1'b1, 1'b1, 5'h0d, 16'h0000);
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      read_defaults();
      phases(3, 1, 2);
      // All ones everywhere; reserved bits and unmapped pairs must stay clear
      for (int i = 0; i < 8; i++) begin
         op(1'b1, 1'b0, i[0], 5'h0a + 5'(i >> 1), 16'hffff);
         op(1'b0, 1'b1, i[0], 5'h0a + 5'(i >> 1), 16'h0000);
      end
      op(1'b1, 1'b0, 1'b1, 5'h0c, 16'h0000);
      op(1'b0, 1'b1, 1'b0, 5'h0c, 16'h0000);
      op(1'b1, 1'b1, 1'b1, 5'h0b, 16'h1234);
      op(1'b0, 1'b1, 1'b1, 5'h0b, 16'h0000);
      phases(0, 4, 5);
      // Random traffic over both banks and the neighbouring offsets
      for (int i = 0; i < 80; i++) begin
         op(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
            5'h0a + 5'($unsigned($random(seed)) % 5), 16'($random(seed)));
         phases($unsigned($random(seed)) % 8, $unsigned($random(seed)) % 8,
                $unsigned($random(seed)) % 8);
      end
      // Reset again in mid-run; every register must be back at its default
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      read_defaults();
      phases(1, 2, 6);
      tally_and_finish();
   end

   // Hang guard
   initial begin
      #250000;
      n_errors++;
      tally_and_finish();
   end
endmodule
